/* File: include/stbs_consts.svh */
// Purpose: named constants for the bus signalling ends
// Assumes: 40 MHz reference clock
// Notes: bus lines are active low on the wire
`ifndef STBS_CONSTS_SVH
`define STBS_CONSTS_SVH
`define STBS_NUM_IDS 8
`define STBS_DATA_W 8
`define STBS_ID_W 3
`define STBS_LUN_W 3
`define STBS_OUR_LUN 3'h0
`define STBS_DISC_SEL_W 3
`define STBS_DISC_DEFAULT 3'h5
`define STBS_CNT_W 16
`define STBS_LEVEL_ASSERTED 1'b0
`define STBS_LEVEL_NEGATED 1'b1
`define STBS_CLK_NS 25
`define STBS_SETTLE_NS 400
`define STBS_SETTLE_CYC ((`STBS_SETTLE_NS + `STBS_CLK_NS - 1) / `STBS_CLK_NS)
`define STBS_ARB_NS 2400
`define STBS_ARB_CYC ((`STBS_ARB_NS + `STBS_CLK_NS - 1) / `STBS_CLK_NS)
`define STBS_TMR_W 8
`endif

/* File: include/stbs_pkg.sv */
// Purpose: shared types for the bus signalling ends
// Assumes: nothing beyond the constants header
// Notes: phase codes are carried as (msg, cd, io) asserted-true bits
package stbs_pkg;
   typedef enum logic [2:0] {
      STBS_PH_DATA_OUT = 3'h0,
      STBS_PH_DATA_IN = 3'h1,
      STBS_PH_COMMAND = 3'h2,
      STBS_PH_STATUS = 3'h3,
      STBS_PH_MSG_OUT = 3'h6,
      STBS_PH_MSG_IN = 3'h7
   } stbs_phase_t;

   // odd parity bit over one byte
   function automatic logic stbs_odd_par(input logic [7:0] b);
      return ~(^b);
   endfunction

   // disconnect size in bytes from the three select jumpers
   function automatic logic [15:0] stbs_disc_bytes(input logic [2:0] sel);
      logic [15:0] r;
      r = 16'h0800;
      unique case (sel)
         3'h0: r = 16'h0800;
         3'h1: r = 16'h1000;
         3'h2: r = 16'h1800;
         3'h3: r = 16'h2000;
         3'h4: r = 16'h3000;
         3'h5: r = 16'h4000;
         3'h6: r = 16'h6000;
         3'h7: r = 16'h8000;
      endcase
      return r;
   endfunction
endpackage

/* File: include/stbs_bus_if.sv */
// Purpose: wired bus between target and initiator ends
// Assumes: each line is open drain, low when any end drives
// Notes: outputs are enables; the resolved level is active low
`timescale 1ns/1ps
interface stbs_bus_if;
   // target drives
   logic t_bsy_oe, t_sel_oe, t_cd_oe, t_io_oe, t_msg_oe, t_req_oe;
   logic [7:0] t_db_oe;
   logic t_dbp_oe;
   // initiator drives
   logic i_bsy_oe, i_sel_oe, i_ack_oe, i_atn_oe, i_rst_oe;
   logic [7:0] i_db_oe;
   logic i_dbp_oe;
   // resolved wire levels, low means asserted
   logic bsy_n, sel_n, cd_n, io_n, msg_n, req_n, ack_n, atn_n, rst_n;
   logic [7:0] db_n;
   logic dbp_n;
   assign bsy_n = ~(t_bsy_oe | i_bsy_oe);
   assign sel_n = ~(t_sel_oe | i_sel_oe);
   assign cd_n = ~t_cd_oe;
   assign io_n = ~t_io_oe;
   assign msg_n = ~t_msg_oe;
   assign req_n = ~t_req_oe;
   assign ack_n = ~i_ack_oe;
   assign atn_n = ~i_atn_oe;
   assign rst_n = ~i_rst_oe;
   assign db_n = ~(t_db_oe | i_db_oe);
   assign dbp_n = ~(t_dbp_oe | i_dbp_oe);

   modport target (
      output t_bsy_oe, t_sel_oe, t_cd_oe, t_io_oe, t_msg_oe, t_req_oe, t_db_oe, t_dbp_oe,
      input bsy_n, sel_n, ack_n, atn_n, rst_n, db_n, dbp_n, io_n
   );
   modport initiator (
      output i_bsy_oe, i_sel_oe, i_ack_oe, i_atn_oe, i_rst_oe, i_db_oe, i_dbp_oe,
      input bsy_n, sel_n, cd_n, io_n, msg_n, req_n, db_n, dbp_n
   );
endinterface

/* File: rtl/stbs_target.sv */
// What this block does
// - at most eight bus IDs, one each
// - eight data lines, parity, nine controls
// - answer any logical unit; flag a nonzero one on o_lun_bad
// - lines asserted low, negated high
// - sense reset line, never drive it
// - busy is wired-or while bus used
// - select by initiator, reselect by target
// - target drives control/data, low is control
// - target drives direction, low toward initiator
// - message line low only in message
// - only target drives request per byte
// - only initiator drives acknowledge
// - initiator raises attention; target observes it
// - arbitrate on own ID bit, seven highest
// - odd parity, checking enabled by jumper
// - ignore parity during arbitration
// - never drive parity high in arbitration
// - reset line is wired-or to all
// - one byte per request/acknowledge handshake
// - highest asserted ID bit wins arbitration
// - data-in burst capped at disconnect size
// Purpose: target end of the parallel bus, seen from the drive
// Assumes: bus inputs synchronous to i_ref_clk; user side handshakes
// Notes: user starts a phase with a byte count; reselect via arbitration
`timescale 1ns/1ps
`include "stbs_consts.svh"
module stbs_target
   import stbs_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // jumpers
   input wire logic [2:0] i_my_id,
   input wire logic i_par_en,
   input wire logic [2:0] i_disc_sel,
   // bus
   stbs_bus_if.target bus,
   // user phase control
   input wire logic i_xfer_start,
   input wire stbs_phase_t i_xfer_phase,
   input wire logic [15:0] i_xfer_len,
   input wire logic i_release,
   input wire logic i_resel_req,
   input wire logic [2:0] i_resel_id,
   // byte streams
   input wire logic [7:0] i_tx_data,
   output logic o_tx_take,
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   // status
   output logic o_selected,
   output logic o_idle,
   output logic o_xfer_done,
   output logic o_atn,
   output logic o_par_err,
   output logic o_bus_reset,
   output logic o_lun_bad
);
   typedef enum logic [2:0] {
      ST_FREE, ST_ARB, ST_RESEL, ST_CONN, ST_REQ, ST_ACKW
   } stbs_tstate_t;

   stbs_tstate_t state_ff;
   logic bsy_ff, sel_ff, req_ff, arb_ff;
   logic [7:0] db_ff;
   logic dbp_ff;
   stbs_phase_t phase_ff;
   logic [15:0] cnt_ff;
   logic [7:0] tmr_ff;
   logic first_ff;

   // wire levels read as asserted-true
   logic bus_rst, bus_bsy, bus_sel, bus_ack, bus_atn, bus_io;
   logic [7:0] bus_db;
   logic bus_dbp, to_init, won;
   assign bus_rst = (bus.rst_n == `STBS_LEVEL_ASSERTED);
   assign bus_bsy = (bus.bsy_n == `STBS_LEVEL_ASSERTED);
   assign bus_sel = (bus.sel_n == `STBS_LEVEL_ASSERTED);
   assign bus_ack = (bus.ack_n == `STBS_LEVEL_ASSERTED);
   assign bus_atn = (bus.atn_n == `STBS_LEVEL_ASSERTED);
   assign bus_io = (bus.io_n == `STBS_LEVEL_ASSERTED);
   assign bus_db = ~bus.db_n;
   assign bus_dbp = ~bus.dbp_n;
   assign to_init = phase_ff[0];
   // no higher id bit than ours asserted wins
   assign won = ((bus_db >> i_my_id) >> 1) == 8'h00;

   // drivers; reset line has no output here
   assign bus.t_bsy_oe = bsy_ff;
   assign bus.t_sel_oe = sel_ff;
   assign bus.t_req_oe = req_ff;
   assign bus.t_cd_oe = (state_ff inside {ST_REQ, ST_ACKW, ST_CONN}) & phase_ff[1];
   assign bus.t_io_oe = (state_ff inside {ST_REQ, ST_ACKW, ST_CONN}) & phase_ff[0]
                        | (state_ff == ST_RESEL);
   assign bus.t_msg_oe = (state_ff inside {ST_REQ, ST_ACKW, ST_CONN}) & phase_ff[2];
   assign bus.t_db_oe = db_ff;
   assign bus.t_dbp_oe = dbp_ff & ~arb_ff;

   assign o_idle = (state_ff == ST_FREE);
   // one pulse per byte, only on the edge that loads it; ack negated
   assign o_tx_take = (state_ff == ST_CONN) & to_init & (cnt_ff != 16'h0000) & first_ff
                      & ~bus_ack;
   assign o_atn = bus_atn;

   // main sequencer
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_ff <= ST_FREE;
         bsy_ff <= 1'b0;
         sel_ff <= 1'b0;
         req_ff <= 1'b0;
         arb_ff <= 1'b0;
         db_ff <= 8'h00;
         dbp_ff <= 1'b0;
         phase_ff <= STBS_PH_DATA_OUT;
         cnt_ff <= 16'h0000;
         tmr_ff <= 8'h00;
         first_ff <= 1'b0;
         o_selected <= 1'b0;
         o_xfer_done <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_data <= 8'h00;
         o_lun_bad <= 1'b0;
      end else if (bus_rst) begin
         state_ff <= ST_FREE;
         bsy_ff <= 1'b0;
         sel_ff <= 1'b0;
         req_ff <= 1'b0;
         arb_ff <= 1'b0;
         db_ff <= 8'h00;
         dbp_ff <= 1'b0;
         o_selected <= 1'b0;
         o_xfer_done <= 1'b0;
         o_rx_valid <= 1'b0;
      end else begin
         o_xfer_done <= 1'b0;
         o_rx_valid <= 1'b0;
         unique case (state_ff)
            ST_FREE: begin
               // selection: sel, our id bit, busy released, io negated
               if (bus_sel && !bus_bsy && !bus_io && bus_db[i_my_id]) begin
                  bsy_ff <= 1'b1;
                  state_ff <= ST_CONN;
                  o_selected <= 1'b1;
                  o_lun_bad <= 1'b0;
               end else if (i_resel_req && !bus_bsy && !bus_sel) begin
                  bsy_ff <= 1'b1;
                  arb_ff <= 1'b1;
                  db_ff <= 8'h01 << i_my_id;
                  tmr_ff <= 8'(`STBS_ARB_CYC);
                  state_ff <= ST_ARB;
               end
            end
            ST_ARB: begin
               // parity is ignored while arbitrating
               if (tmr_ff != 8'h00) begin
                  tmr_ff <= tmr_ff - 8'h01;
               end else if (won && !bus_sel) begin
                  sel_ff <= 1'b1;
                  arb_ff <= 1'b0;
                  db_ff <= (8'h01 << i_my_id) | (8'h01 << i_resel_id);
                  dbp_ff <= stbs_odd_par((8'h01 << i_my_id) | (8'h01 << i_resel_id));
                  tmr_ff <= 8'(`STBS_SETTLE_CYC);
                  state_ff <= ST_RESEL;
               end else begin
                  bsy_ff <= 1'b0; // lost
                  arb_ff <= 1'b0;
                  db_ff <= 8'h00;
                  state_ff <= ST_FREE;
               end
            end
            ST_RESEL: begin
               // initiator answers by asserting busy; we drop ours meanwhile
               if (tmr_ff != 8'h00) begin
                  tmr_ff <= tmr_ff - 8'h01;
                  bsy_ff <= 1'b0;
               end else if (bus_bsy) begin
                  bsy_ff <= 1'b1;
                  sel_ff <= 1'b0;
                  db_ff <= 8'h00;
                  dbp_ff <= 1'b0;
                  o_selected <= 1'b1;
                  state_ff <= ST_CONN;
               end
            end
            ST_CONN: begin
               if (i_release) begin
                  bsy_ff <= 1'b0;
                  o_selected <= 1'b0;
                  state_ff <= ST_FREE;
               end else if (i_xfer_start) begin
                  phase_ff <= i_xfer_phase;
                  first_ff <= 1'b1;
                  if (i_xfer_phase == STBS_PH_DATA_IN && i_xfer_len > stbs_disc_bytes(i_disc_sel))
                     cnt_ff <= stbs_disc_bytes(i_disc_sel);
                  else
                     cnt_ff <= i_xfer_len;
               end else if (first_ff && cnt_ff == 16'h0000) begin
                  first_ff <= 1'b0;
                  o_xfer_done <= 1'b1;
               end else if (first_ff && !bus_ack) begin
                  if (to_init) begin
                     db_ff <= i_tx_data;
                     dbp_ff <= stbs_odd_par(i_tx_data);
                  end
                  tmr_ff <= 8'(`STBS_SETTLE_CYC);
                  state_ff <= ST_REQ;
               end
            end
            ST_REQ: begin
               // settle data, then raise request
               if (tmr_ff != 8'h00) begin
                  tmr_ff <= tmr_ff - 8'h01;
               end else begin
                  req_ff <= 1'b1;
                  state_ff <= ST_ACKW;
               end
            end
            ST_ACKW: begin
               if (bus_ack) begin
                  req_ff <= 1'b0;
                  cnt_ff <= cnt_ff - 16'h0001;
                  if (!to_init) begin
                     o_rx_data <= bus_db;
                     o_rx_valid <= 1'b1;
                     // identify message carries the unit in low bits
                     if (phase_ff == STBS_PH_MSG_OUT && bus_db[7]
                         && bus_db[2:0] != `STBS_OUR_LUN)
                        o_lun_bad <= 1'b1;
                  end
                  db_ff <= 8'h00;
                  dbp_ff <= 1'b0;
                  state_ff <= ST_CONN;
               end
            end
            default: state_ff <= ST_FREE;
         endcase
      end
   end

   // sticky parity error on received bytes, cleared while the target is free
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_par_err <= 1'b0;
      end else if (state_ff == ST_ACKW && bus_ack && !to_init && i_par_en
                   && bus_dbp != stbs_odd_par(bus_db)) begin
         o_par_err <= 1'b1;
      end else if (state_ff == ST_FREE) begin
         o_par_err <= 1'b0;
      end
   end

   // registered reset indication
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         o_bus_reset <= 1'b0;
      else
         o_bus_reset <= bus_rst;
   end
endmodule

/* File: rtl/stbs_initiator.sv */
// Purpose: initiator end of the parallel bus
// Assumes: bus inputs synchronous to i_ref_clk
// Notes: selects a target, then answers each request with one ack
`timescale 1ns/1ps
`include "stbs_consts.svh"
module stbs_initiator
   import stbs_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // configuration
   input wire logic [2:0] i_my_id,
   // bus
   stbs_bus_if.initiator bus,
   // user control
   input wire logic i_select,
   input wire logic [2:0] i_target_id,
   input wire logic i_atn_req,
   input wire logic i_bus_reset,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_take,
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   output logic [2:0] o_phase,
   output logic o_connected,
   output logic o_par_err
);
   typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_WAIT, ST_CONN, ST_ACK} stbs_istate_t;

   stbs_istate_t state_ff;
   logic sel_ff, ack_ff, bsy_ff, atn_ff, rst_ff;
   logic [7:0] db_ff;
   logic dbp_ff;
   logic bus_bsy, bus_req, bus_io, resel;
   assign bus_bsy = (bus.bsy_n == `STBS_LEVEL_ASSERTED);
   assign bus_req = (bus.req_n == `STBS_LEVEL_ASSERTED);
   assign bus_io = (bus.io_n == `STBS_LEVEL_ASSERTED);
   assign resel = (bus.sel_n == `STBS_LEVEL_ASSERTED) && bus_io && ~bus.db_n[i_my_id];

   assign bus.i_sel_oe = sel_ff;
   assign bus.i_ack_oe = ack_ff;
   assign bus.i_bsy_oe = bsy_ff;
   assign bus.i_atn_oe = atn_ff;
   assign bus.i_rst_oe = rst_ff;
   assign bus.i_db_oe = db_ff;
   assign bus.i_dbp_oe = dbp_ff;
   assign o_tx_take = (state_ff == ST_CONN) & bus_req & ~bus_io;
   assign o_phase = {~bus.msg_n, ~bus.cd_n, ~bus.io_n};

   // sequencer
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_ff <= ST_IDLE;
         sel_ff <= 1'b0;
         ack_ff <= 1'b0;
         bsy_ff <= 1'b0;
         db_ff <= 8'h00;
         dbp_ff <= 1'b0;
         o_rx_data <= 8'h00;
         o_rx_valid <= 1'b0;
         o_connected <= 1'b0;
         o_par_err <= 1'b0;
      end else if (rst_ff) begin
         state_ff <= ST_IDLE;
         sel_ff <= 1'b0;
         ack_ff <= 1'b0;
         bsy_ff <= 1'b0;
         db_ff <= 8'h00;
         dbp_ff <= 1'b0;
         o_connected <= 1'b0;
         o_rx_valid <= 1'b0;
      end else begin
         o_rx_valid <= 1'b0;
         unique case (state_ff)
            ST_IDLE: begin
               if (resel) begin
                  bsy_ff <= 1'b1; // answer reselection
                  state_ff <= ST_WAIT;
               end else if (i_select && !bus_bsy) begin
                  sel_ff <= 1'b1;
                  db_ff <= (8'h01 << i_my_id) | (8'h01 << i_target_id);
                  dbp_ff <= stbs_odd_par((8'h01 << i_my_id) | (8'h01 << i_target_id));
                  state_ff <= ST_SEL;
               end
            end
            ST_SEL: begin
               if (bus_bsy) begin
                  sel_ff <= 1'b0;
                  db_ff <= 8'h00;
                  dbp_ff <= 1'b0;
                  o_connected <= 1'b1;
                  state_ff <= ST_CONN;
               end
            end
            ST_WAIT: begin
               // target drops select once it holds busy again
               if (bus.sel_n) begin
                  bsy_ff <= 1'b0;
                  o_connected <= 1'b1;
                  state_ff <= ST_CONN;
               end
            end
            ST_CONN: begin
               if (!bus_bsy) begin
                  o_connected <= 1'b0;
                  state_ff <= ST_IDLE;
               end else if (bus_req) begin
                  if (bus_io) begin
                     o_rx_data <= ~bus.db_n;
                     o_rx_valid <= 1'b1;
                     o_par_err <= o_par_err | (~bus.dbp_n != stbs_odd_par(~bus.db_n));
                  end else begin
                     db_ff <= i_tx_data;
                     dbp_ff <= stbs_odd_par(i_tx_data);
                  end
                  ack_ff <= 1'b1;
                  state_ff <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (!bus_req) begin
                  ack_ff <= 1'b0;
                  db_ff <= 8'h00;
                  dbp_ff <= 1'b0;
                  state_ff <= ST_CONN;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // attention and reset lines follow user requests
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         atn_ff <= 1'b0;
         rst_ff <= 1'b0;
      end else begin
         atn_ff <= i_atn_req;
         rst_ff <= i_bus_reset;
      end
   end
endmodule

/* File: bench/stbs_bus_monitor.sv */
// Purpose: concurrent checks on the wired bus joining target and initiator ends
// Assumes: every line but atn_n sampled on i_ref_clk; a line is low when asserted
// Notes: TGT_ID is the bus id jumpered into the target end
`timescale 1ns/1ps
module stbs_bus_monitor #(
   parameter int TGT_ID = 0
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // target enables
   input wire logic t_bsy_oe,
   input wire logic t_sel_oe,
   input wire logic [7:0] t_db_oe,
   // resolved lines
   input wire logic bsy_n,
   input wire logic sel_n,
   input wire logic cd_n,
   input wire logic io_n,
   input wire logic msg_n,
   input wire logic req_n,
   input wire logic ack_n,
   input wire logic rst_n,
   input wire logic [7:0] db_n,
   input wire logic dbp_n
);
   default clocking mon_cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   // request waiting for its acknowledge, and a bus reset held long enough to act
   sequence req_waiting;
      !req_n && ack_n && rst_n;
   endsequence
   sequence rst_held;
      !rst_n [*3];
   endsequence
   sequence sel_for_us;
      !sel_n && bsy_n && io_n && !db_n[TGT_ID] && rst_n;
   endsequence

   // handshake order and holding
   a_req_stands: assert property (req_waiting |=> !req_n)
      else $error("request dropped before acknowledge");
   a_req_drops: assert property ($fell(ack_n) |-> ##[1:4] req_n)
      else $error("request not dropped after acknowledge");
   a_ack_on_req: assert property ($fell(ack_n) |-> !req_n)
      else $error("acknowledge without request");
   a_data_stable: assert property ((!req_n && !io_n) ##1 !req_n |-> $stable(db_n))
      else $error("data moved while request held");
   // parity, phase encoding and request inside a connection
   a_par_in_odd: assert property (!req_n && !io_n && !bsy_n |-> ^{~db_n, ~dbp_n})
      else $error("even parity from target");
   a_par_out_odd: assert property (!ack_n && io_n |-> ^{~db_n, ~dbp_n})
      else $error("even parity from initiator");
   a_msg_is_ctrl: assert property (!msg_n |-> !cd_n && !bsy_n)
      else $error("message line outside a message phase");
   a_req_in_conn: assert property (!req_n |-> !bsy_n && sel_n)
      else $error("request outside a connection");
   // selection, arbitration and bus reset
   a_sel_answer: assert property (sel_for_us |-> ##[1:4] !bsy_n)
      else $error("target did not answer selection");
   a_arb_own_bit: assert property (t_bsy_oe && !t_sel_oe && io_n && (|t_db_oe)
      |-> t_db_oe == (8'h01 << TGT_ID))
      else $error("arbitration on a foreign data bit");
   a_rst_release: assert property (rst_held |-> cd_n && io_n && msg_n && req_n
      && !t_bsy_oe && !t_sel_oe && t_db_oe == 8'h00)
      else $error("target still drives during bus reset");
endmodule

/* File: bench/test_scsi_target_bus_signalling.sv */
// Purpose: self-checking bench joining the target and initiator ends
// Assumes: target id 0, initiator id 7, parity checking on
// Notes: rows cover every phase; hand tests cover clip, unit, attention, reset
`timescale 1ns/1ps
module test_scsi_target_bus_signalling import stbs_pkg::*; ;
   typedef struct {stbs_phase_t ph; logic [15:0] len; logic [7:0] b;} stbs_row_t;
   logic i_ref_clk, i_rst_b;
   logic t_start, t_release, t_resel_req, t_take, t_rx_valid, t_selected, t_idle, t_done;
   logic t_atn, t_par_err, t_bus_reset, t_lun_bad;
   stbs_phase_t t_phase;
   logic [15:0] t_len;
   logic [7:0] t_tx, t_rx, t_last, h_tx, h_rx, h_last;
   logic [2:0] disc_sel, tgt_id, h_phase, seen_ph;
   logic h_select, h_atn_req, h_bus_reset, h_take, h_rx_valid, h_connected, h_par_err;
   int errors, compares, cycles, t_cnt, h_cnt, k_cnt, n;
   stbs_row_t rows [6] = '{'{STBS_PH_DATA_OUT, 16'h0003, 8'hA5},
      '{STBS_PH_DATA_IN, 16'h0004, 8'h3C}, '{STBS_PH_COMMAND, 16'h0006, 8'h12},
      '{STBS_PH_STATUS, 16'h0001, 8'h00}, '{STBS_PH_MSG_OUT, 16'h0001, 8'hC0},
      '{STBS_PH_MSG_IN, 16'h0001, 8'hFF}};

   stbs_bus_if bus ();
   stbs_target u_stbs_target (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_my_id(3'h0),
      .i_par_en(1'b1), .i_disc_sel(disc_sel), .bus(bus), .i_xfer_start(t_start),
      .i_xfer_phase(t_phase), .i_xfer_len(t_len), .i_release(t_release),
      .i_resel_req(t_resel_req), .i_resel_id(3'h7), .i_tx_data(t_tx), .o_tx_take(t_take),
      .o_rx_data(t_rx), .o_rx_valid(t_rx_valid), .o_selected(t_selected), .o_idle(t_idle),
      .o_xfer_done(t_done), .o_atn(t_atn), .o_par_err(t_par_err),
      .o_bus_reset(t_bus_reset), .o_lun_bad(t_lun_bad));
   stbs_initiator u_stbs_initiator (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_my_id(3'h7), .bus(bus), .i_select(h_select), .i_target_id(tgt_id),
      .i_atn_req(h_atn_req), .i_bus_reset(h_bus_reset), .i_tx_data(h_tx),
      .o_tx_take(h_take), .o_rx_data(h_rx), .o_rx_valid(h_rx_valid), .o_phase(h_phase),
      .o_connected(h_connected), .o_par_err(h_par_err));
   stbs_bus_monitor #(.TGT_ID(0)) u_stbs_bus_monitor (.i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b), .t_bsy_oe(bus.t_bsy_oe), .t_sel_oe(bus.t_sel_oe),
      .t_db_oe(bus.t_db_oe), .bsy_n(bus.bsy_n), .sel_n(bus.sel_n), .cd_n(bus.cd_n),
      .io_n(bus.io_n), .msg_n(bus.msg_n), .req_n(bus.req_n), .ack_n(bus.ack_n),
      .rst_n(bus.rst_n), .db_n(bus.db_n), .dbp_n(bus.dbp_n));

   // 25 ns reference clock
   initial begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   // byte counters, phase seen at each request, and the hang limit
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (t_rx_valid) begin
         t_cnt <= t_cnt + 1;
         t_last <= t_rx;
      end
      if (h_rx_valid) begin
         h_cnt <= h_cnt + 1;
         h_last <= h_rx;
      end
      // bytes pulled from the sending end's user side
      if (t_take || h_take) k_cnt <= k_cnt + 1;
      if (!bus.req_n) seen_ph <= h_phase;
      if (cycles == 60000) begin
         errors++;
         $display("[FAIL] %0t ns run exceeded its cycle limit", $time);
         conclude();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t ns %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one transfer phase started on the target, both ends offering the same byte
   task automatic xfer(input stbs_phase_t ph, input logic [15:0] len, input logic [7:0] b);
      t_phase = ph;
      t_len = len;
      t_tx = b;
      h_tx = b;
      t_cnt = 0;
      h_cnt = 0;
      k_cnt = 0;
      t_start = 1'b1;
      @(negedge i_ref_clk);
      t_start = 1'b0;
      for (n = 0; n < 50000 && t_done !== 1'b1; n++) @(negedge i_ref_clk);
      repeat (4) @(negedge i_ref_clk);
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      {i_rst_b, t_start, t_release, t_resel_req, h_select, h_atn_req, h_bus_reset} = '0;
      t_phase = STBS_PH_DATA_OUT;
      {t_len, t_tx, h_tx, disc_sel, tgt_id} = '0;
      {errors, compares, cycles, t_cnt, h_cnt, k_cnt} = '0;
      repeat (4) @(negedge i_ref_clk);
      i_rst_b = 1'b1;
      @(negedge i_ref_clk);
      check({bus.bsy_n, bus.sel_n, bus.req_n, bus.ack_n, bus.db_n}, 16'h0FFF, "idle lines");
      check(t_idle, 1'b1, "target idle after reset");
      $display("test reset done");
      h_select = 1'b1;
      for (n = 0; n < 400 && h_connected !== 1'b1; n++) @(negedge i_ref_clk);
      check(h_connected, 1'b1, "initiator connected");
      check(t_selected, 1'b1, "target selected");
      check(bus.bsy_n, 1'b0, "busy held while connected");
      $display("test select done");
      foreach (rows[i]) begin
         xfer(rows[i].ph, rows[i].len, rows[i].b);
         check(seen_ph, rows[i].ph, "phase lines");
         check(rows[i].ph[0] ? h_cnt[15:0] : t_cnt[15:0], rows[i].len, "byte count");
         check(rows[i].ph[0] ? h_last : t_last, rows[i].b, "byte value");
         check(k_cnt[15:0], rows[i].len, "bytes taken by sender");
      end
      check({t_lun_bad, t_par_err, h_par_err}, 16'h0000, "flags after rows");
      $display("test phase rows done");
      xfer(STBS_PH_DATA_IN, 16'h0801, 8'h5A);
      check(h_cnt[15:0], 16'h0800, "data-in clipped to 2K");
      check(h_last, 8'h5A, "clipped burst data");
      $display("test disconnect clip done");
      xfer(STBS_PH_MSG_OUT, 16'h0001, 8'h81);
      check(t_lun_bad, 1'b1, "nonzero unit flagged");
      $display("test unit address done");
      h_atn_req = 1'b1;
      repeat (4) @(negedge i_ref_clk);
      check({bus.atn_n, t_atn}, 16'h0001, "attention seen");
      h_atn_req = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      check(t_atn, 1'b0, "attention cleared");
      $display("test attention done");
      h_select = 1'b0;
      t_release = 1'b1;
      @(negedge i_ref_clk);
      t_release = 1'b0;
      for (n = 0; n < 100 && bus.bsy_n !== 1'b1; n++) @(negedge i_ref_clk);
      check({bus.bsy_n, t_idle}, 16'h0003, "bus free after release");
      $display("test release done");
      t_resel_req = 1'b1;
      for (n = 0; n < 400 && {bus.sel_n, bus.io_n} !== 2'b00; n++) @(negedge i_ref_clk);
      check({bus.sel_n, bus.io_n}, 16'h0000, "reselection lines");
      check(~bus.db_n & 8'h81, 16'h0081, "reselection ids");
      t_resel_req = 1'b0;
      $display("test reselection done");
      h_bus_reset = 1'b1;
      repeat (4) @(negedge i_ref_clk);
      check({bus.rst_n, t_bus_reset}, 16'h0001, "bus reset sensed");
      check({bus.t_bsy_oe, bus.t_sel_oe, bus.t_req_oe, bus.t_io_oe, bus.t_db_oe}, 16'h0000,
         "target released");
      h_bus_reset = 1'b0;
      repeat (8) @(negedge i_ref_clk);
      check(t_idle, 1'b1, "target free after bus reset");
      $display("test bus reset done");
      conclude();
   end
endmodule
